/* File: rtl/nplf_pkg.sv */
// package for the per-frame noise pause and prediction gain feature block
package nplf_pkg;
    // values are signed fixed point with 12 fraction bits
    localparam int FRAC_BITS = 12;
    localparam int VAL_W = 24;
    localparam int CNT_W = 16;
    localparam int NRG_W = 32;
    localparam int COEF_W = 13;

    // coefficients as round(c * 4096)
    localparam logic [COEF_W-1:0] COEF_0P15 = 13'h0266;
    localparam logic [COEF_W-1:0] COEF_0P10 = 13'h019a;
    localparam logic [COEF_W-1:0] COEF_0P20 = 13'h0333;
    localparam logic [COEF_W-1:0] COEF_0P03 = 13'h007b;
    localparam logic [COEF_W-1:0] COEF_0P02 = 13'h0052;
    localparam logic [COEF_W-1:0] COEF_0P05 = 13'h00cd;

    // thresholds in the same fixed point
    localparam logic signed [VAL_W-1:0] GAIN_MAX = 24'sh008000;
    localparam logic signed [VAL_W-1:0] RISE_THR = 24'sh005000;
    localparam logic signed [VAL_W-1:0] NEAR_THR = 24'sh00a000;
    localparam logic signed [VAL_W-1:0] TRACK_THR = 24'sh0000cd;
    localparam logic signed [VAL_W-1:0] ONE_VAL = 24'sh001000;

    localparam logic signed [CNT_W-1:0] PAUSE_ACTIVE = 16'shffff;
    localparam logic signed [CNT_W-1:0] PAUSE_RESET = 16'sh0000;
    localparam logic signed [CNT_W-1:0] PAUSE_MAX = 16'sh7fff;
    localparam logic [CNT_W-1:0] RUN_MAX = 16'hffff;
    localparam logic signed [VAL_W-1:0] VAL_RESET = 24'sh000000;

    typedef struct packed {
        logic signed [VAL_W-1:0] frame_energy;
        logic signed [VAL_W-1:0] long_term_min_energy;
        logic signed [VAL_W-1:0] noise_level;
        logic [NRG_W-1:0] energy_order0;
        logic [NRG_W-1:0] energy_order2;
        logic [NRG_W-1:0] energy_order16;
    } nplf_frame_type;

    typedef struct packed {
        logic signed [CNT_W-1:0] energy_pause_counter;
        logic signed [VAL_W-1:0] low_order_pred_gain;
        logic signed [VAL_W-1:0] low_gain_avg;
        logic signed [VAL_W-1:0] low_dev;
        logic signed [VAL_W-1:0] low_dev_avg;
        logic signed [VAL_W-1:0] low_peak;
        logic signed [VAL_W-1:0] high_order_pred_gain;
        logic signed [VAL_W-1:0] high_fast_avg;
        logic signed [VAL_W-1:0] slow_high_order_avg;
        logic signed [VAL_W-1:0] high_dev;
        logic signed [VAL_W-1:0] high_dev_avg;
        logic signed [VAL_W-1:0] high_peak;
        logic signed [VAL_W-1:0] noise_distance;
        logic signed [VAL_W-1:0] noise_track;
        logic [CNT_W-1:0] near_noise_run;
        logic signed [VAL_W-1:0] min_energy_distance;
    } nplf_feat_type;
endpackage

/* File: rtl/nplf_features.sv */
// per-frame pause counter, prediction gain and noise distance features
`timescale 1ns/100ps
module nplf_features (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    input wire logic I_FRAME_STB,
    input wire nplf_pkg::nplf_frame_type I_FRAME,
    output logic O_FEAT_VALID,
    output nplf_pkg::nplf_feat_type O_FEAT
);
    import nplf_pkg::*;

    // first-order recursion y + a*(x - y)
    function automatic logic signed [VAL_W-1:0] smooth(
        input logic signed [VAL_W-1:0] y,
        input logic signed [VAL_W-1:0] x,
        input logic [COEF_W-1:0] a
    );
        logic signed [VAL_W:0] d;
        logic signed [VAL_W+COEF_W+1:0] p;
        d = {x[VAL_W-1], x} - {y[VAL_W-1], y};
        p = d * $signed({1'b0, a});
        smooth = y + p[VAL_W+FRAC_BITS-1:FRAC_BITS];
    endfunction

    // energy ratio, clamped to 0..8; a zero divisor saturates
    function automatic logic signed [VAL_W-1:0] ratio_gain(
        input logic [NRG_W-1:0] num,
        input logic [NRG_W-1:0] den
    );
        logic [NRG_W+FRAC_BITS-1:0] q;
        q = '0;
        if (den == '0) begin
            ratio_gain = GAIN_MAX;
        end else begin
            q = {num, {FRAC_BITS{1'b0}}} / {{FRAC_BITS{1'b0}}, den};
            if (q > {{(NRG_W+FRAC_BITS-VAL_W){1'b0}}, GAIN_MAX}) begin
                ratio_gain = GAIN_MAX;
            end else begin
                ratio_gain = q[VAL_W-1:0];
            end
        end
    endfunction

    function automatic logic signed [VAL_W-1:0] max_val(
        input logic signed [VAL_W-1:0] a,
        input logic signed [VAL_W-1:0] b
    );
        max_val = (a > b) ? a : b;
    endfunction

    nplf_feat_type feat_r;
    nplf_feat_type feat_nxt;
    logic valid_r;

    // frame energy differences
    wire logic signed [VAL_W-1:0] rise_min = I_FRAME.frame_energy - I_FRAME.long_term_min_energy;
    wire logic signed [VAL_W-1:0] rise_noise = I_FRAME.frame_energy - I_FRAME.noise_level;

    // pause counter steps
    wire logic pause_inactive = feat_r.energy_pause_counter >= PAUSE_RESET;
    wire logic pause_to_active = pause_inactive && (rise_min > RISE_THR);
    wire logic pause_to_idle = (feat_r.energy_pause_counter == PAUSE_ACTIVE)
        && (rise_min < RISE_THR);
    wire logic signed [CNT_W-1:0] pause_mid = pause_to_active ? PAUSE_ACTIVE
        : pause_to_idle ? PAUSE_RESET : feat_r.energy_pause_counter;
    // increment last, saturating so a long pause never wraps to active
    wire logic signed [CNT_W-1:0] pause_new = (pause_mid < PAUSE_RESET) ? pause_mid
        : (pause_mid == PAUSE_MAX) ? pause_mid : pause_mid + 16'sh0001;

    // low-order prediction features
    wire logic signed [VAL_W-1:0] low_gain =
        ratio_gain(I_FRAME.energy_order0, I_FRAME.energy_order2);
    wire logic signed [VAL_W-1:0] low_avg_new =
        smooth(feat_r.low_gain_avg, low_gain, COEF_0P15);
    wire logic signed [VAL_W-1:0] low_diff = low_avg_new - low_gain;
    wire logic signed [VAL_W-1:0] low_dev_new = low_diff[VAL_W-1] ? -low_diff : low_diff;
    wire logic [COEF_W-1:0] low_dev_coef =
        (low_dev_new < feat_r.low_dev_avg) ? COEF_0P10 : COEF_0P20;
    wire logic signed [VAL_W-1:0] low_dev_avg_new =
        smooth(feat_r.low_dev_avg, low_dev_new, low_dev_coef);
    wire logic signed [VAL_W-1:0] low_peak_new = max_val(low_dev_avg_new, low_dev_new);

    // high-order prediction features
    wire logic signed [VAL_W-1:0] high_gain =
        ratio_gain(I_FRAME.energy_order2, I_FRAME.energy_order16);
    wire logic [COEF_W-1:0] high_fast_coef =
        (high_gain > feat_r.high_fast_avg) ? COEF_0P20 : COEF_0P03;
    wire logic signed [VAL_W-1:0] high_fast_new =
        smooth(feat_r.high_fast_avg, high_gain, high_fast_coef);
    wire logic signed [VAL_W-1:0] high_slow_new =
        smooth(feat_r.slow_high_order_avg, high_gain, COEF_0P02);
    wire logic signed [VAL_W-1:0] high_dev_new = high_fast_new - high_slow_new;
    wire logic [COEF_W-1:0] high_dev_coef =
        (high_dev_new < feat_r.high_dev_avg) ? COEF_0P02 : COEF_0P05;
    wire logic signed [VAL_W-1:0] high_dev_avg_new =
        smooth(feat_r.high_dev_avg, high_dev_new, high_dev_coef);
    wire logic signed [VAL_W-1:0] high_peak_new = max_val(high_dev_avg_new, high_dev_new);

    // noise distance and tracking
    wire logic signed [VAL_W-1:0] noise_dist_new =
        smooth(feat_r.noise_distance, rise_noise, COEF_0P03);
    wire logic signed [VAL_W-1:0] near_ind = (rise_noise < NEAR_THR) ? ONE_VAL : VAL_RESET;
    wire logic signed [VAL_W-1:0] track_new = smooth(feat_r.noise_track, near_ind, COEF_0P03);
    wire logic track_high = track_new >= TRACK_THR;
    wire logic [CNT_W-1:0] run_new = track_high ? '0
        : (feat_r.near_noise_run == RUN_MAX) ? RUN_MAX
        : feat_r.near_noise_run + 16'h0001;
    wire logic signed [VAL_W-1:0] min_dist_new =
        smooth(feat_r.min_energy_distance, rise_min, COEF_0P03);

    always_comb begin
        feat_nxt = feat_r;
        if (I_FRAME_STB) begin
            feat_nxt.energy_pause_counter = pause_new;
            feat_nxt.low_order_pred_gain = low_gain;
            feat_nxt.low_gain_avg = low_avg_new;
            feat_nxt.low_dev = low_dev_new;
            feat_nxt.low_dev_avg = low_dev_avg_new;
            feat_nxt.low_peak = low_peak_new;
            feat_nxt.high_order_pred_gain = high_gain;
            feat_nxt.high_fast_avg = high_fast_new;
            feat_nxt.slow_high_order_avg = high_slow_new;
            feat_nxt.high_dev = high_dev_new;
            feat_nxt.high_dev_avg = high_dev_avg_new;
            feat_nxt.high_peak = high_peak_new;
            feat_nxt.noise_distance = noise_dist_new;
            feat_nxt.noise_track = track_new;
            feat_nxt.near_noise_run = run_new;
            feat_nxt.min_energy_distance = min_dist_new;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            feat_r <= '0;
            valid_r <= 1'b0;
        end else begin
            feat_r <= feat_nxt;
            valid_r <= I_FRAME_STB;
        end
    end

    assign O_FEAT = feat_r;
    assign O_FEAT_VALID = valid_r;

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_B);

    a_pause_goes_active: assert property (
        I_FRAME_STB && feat_r.energy_pause_counter >= 16'sh0000 && rise_min > RISE_THR
        |=> feat_r.energy_pause_counter == PAUSE_ACTIVE)
        else $error("pause counter did not enter active");

    a_pause_release: assert property (
        I_FRAME_STB && feat_r.energy_pause_counter == PAUSE_ACTIVE && rise_min < RISE_THR
        |=> feat_r.energy_pause_counter == 16'sh0001)
        else $error("pause counter did not release to first pause frame");

    a_pause_held_active: assert property (
        I_FRAME_STB && feat_r.energy_pause_counter == PAUSE_ACTIVE && rise_min >= RISE_THR
        |=> feat_r.energy_pause_counter == PAUSE_ACTIVE)
        else $error("active pause counter changed without energy drop");

    a_pause_counts_up: assert property (
        I_FRAME_STB && feat_r.energy_pause_counter >= 16'sh0000
        && feat_r.energy_pause_counter < PAUSE_MAX && rise_min <= RISE_THR
        |=> feat_r.energy_pause_counter == $past(feat_r.energy_pause_counter) + 16'sh0001)
        else $error("pause counter did not count up");

    a_gains_clamped: assert property (
        feat_r.low_order_pred_gain >= 24'sh000000 && feat_r.low_order_pred_gain <= GAIN_MAX
        && feat_r.high_order_pred_gain >= 24'sh000000 && feat_r.high_order_pred_gain <= GAIN_MAX)
        else $error("prediction gain out of range");

    a_low_peak_max: assert property (
        feat_r.low_peak >= feat_r.low_dev_avg && feat_r.low_peak >= feat_r.low_dev
        && (feat_r.low_peak == feat_r.low_dev_avg || feat_r.low_peak == feat_r.low_dev))
        else $error("low peak is not the larger deviation");

    a_high_dev_signed: assert property (
        I_FRAME_STB |=> feat_r.high_dev == feat_r.high_fast_avg - feat_r.slow_high_order_avg)
        else $error("high deviation is not fast minus slow");

    a_high_peak_max: assert property (
        feat_r.high_peak >= feat_r.high_dev_avg && feat_r.high_peak >= feat_r.high_dev)
        else $error("high peak below a deviation");

    a_run_reset: assert property (
        I_FRAME_STB && track_high |=> feat_r.near_noise_run == 16'h0000)
        else $error("near-noise run not cleared");

    a_run_incr: assert property (
        I_FRAME_STB && !track_high && feat_r.near_noise_run != RUN_MAX
        |=> feat_r.near_noise_run == $past(feat_r.near_noise_run) + 16'h0001)
        else $error("near-noise run not incremented");

    a_idle_no_update: assert property (
        !I_FRAME_STB |=> $stable(feat_r) && !O_FEAT_VALID)
        else $error("state changed without frame strobe");

    a_valid_follows: assert property (
        I_FRAME_STB |=> O_FEAT_VALID)
        else $error("valid did not follow strobe");

    // each stored gain, average, deviation, peak and distance must be the value worked out in the strobe cycle
    a_low_gain_reg: assert property (
        I_FRAME_STB |=> feat_r.low_order_pred_gain == $past(low_gain))
        else $error("low gain not stored");

    a_low_avg_reg: assert property (
        I_FRAME_STB |=> feat_r.low_gain_avg == $past(low_avg_new))
        else $error("low gain average not stored");

    a_low_dev_pos: assert property (
        feat_r.low_dev >= 24'sh000000)
        else $error("low deviation negative");

    a_low_dev_reg: assert property (
        I_FRAME_STB |=> feat_r.low_dev == $past(low_dev_new))
        else $error("low deviation not stored");

    a_low_coef_fall: assert property (
        I_FRAME_STB && low_dev_new < feat_r.low_dev_avg
        |-> low_dev_coef == COEF_0P10)
        else $error("low deviation falling coefficient wrong");

    a_low_coef_rise: assert property (
        I_FRAME_STB && low_dev_new >= feat_r.low_dev_avg
        |-> low_dev_coef == COEF_0P20)
        else $error("low deviation rising coefficient wrong");

    a_low_davg_reg: assert property (
        I_FRAME_STB |=> feat_r.low_dev_avg == $past(low_dev_avg_new))
        else $error("low deviation average not stored");

    a_low_peak_reg: assert property (
        I_FRAME_STB |=> feat_r.low_peak == $past(low_peak_new))
        else $error("low peak not stored");

    a_high_gain_reg: assert property (
        I_FRAME_STB |=> feat_r.high_order_pred_gain == $past(high_gain))
        else $error("high gain not stored");

    a_fast_coef_up: assert property (
        I_FRAME_STB && high_gain > feat_r.high_fast_avg
        |-> high_fast_coef == COEF_0P20)
        else $error("fast average rising coefficient wrong");

    a_fast_coef_down: assert property (
        I_FRAME_STB && high_gain <= feat_r.high_fast_avg
        |-> high_fast_coef == COEF_0P03)
        else $error("fast average falling coefficient wrong");

    a_high_fast_reg: assert property (
        I_FRAME_STB |=> feat_r.high_fast_avg == $past(high_fast_new))
        else $error("fast average not stored");

    a_high_slow_reg: assert property (
        I_FRAME_STB |=> feat_r.slow_high_order_avg == $past(high_slow_new))
        else $error("slow average not stored");

    a_hdev_coef_fall: assert property (
        I_FRAME_STB && high_dev_new < feat_r.high_dev_avg
        |-> high_dev_coef == COEF_0P02)
        else $error("high deviation falling coefficient wrong");

    a_hdev_coef_rise: assert property (
        I_FRAME_STB && high_dev_new >= feat_r.high_dev_avg
        |-> high_dev_coef == COEF_0P05)
        else $error("high deviation rising coefficient wrong");

    a_high_davg_reg: assert property (
        I_FRAME_STB |=> feat_r.high_dev_avg == $past(high_dev_avg_new))
        else $error("high deviation average not stored");

    a_high_peak_reg: assert property (
        I_FRAME_STB |=> feat_r.high_peak == $past(high_peak_new))
        else $error("high peak not stored");

    a_noise_dist_reg: assert property (
        I_FRAME_STB |=> feat_r.noise_distance == $past(noise_dist_new))
        else $error("noise distance not stored");

    a_near_ind_one: assert property (
        rise_noise < NEAR_THR |-> near_ind == ONE_VAL)
        else $error("near indicator not one");

    a_near_ind_zero: assert property (
        rise_noise >= NEAR_THR |-> near_ind == VAL_RESET)
        else $error("near indicator not zero");

    a_track_range: assert property (
        feat_r.noise_track >= 24'sh000000 && feat_r.noise_track <= ONE_VAL)
        else $error("noise tracking out of range");

    a_min_dist_reg: assert property (
        I_FRAME_STB |=> feat_r.min_energy_distance == $past(min_dist_new))
        else $error("min energy distance not stored");

    a_pause_floor: assert property (
        feat_r.energy_pause_counter >= PAUSE_ACTIVE)
        else $error("pause counter below active value");

    a_run_saturates: assert property (
        I_FRAME_STB && !track_high && feat_r.near_noise_run == RUN_MAX
        |=> feat_r.near_noise_run == RUN_MAX)
        else $error("near-noise run wrapped");

    c_high_clamp: cover property (I_FRAME_STB && high_gain == GAIN_MAX);
    c_pause_active: cover property (
        feat_r.energy_pause_counter >= 16'sh0000 ##1 feat_r.energy_pause_counter == PAUSE_ACTIVE);
    c_pause_return: cover property (
        feat_r.energy_pause_counter == PAUSE_ACTIVE ##1 feat_r.energy_pause_counter == 16'sh0001);
    c_run_cleared: cover property (
        feat_r.near_noise_run != 16'h0000 ##1 feat_r.near_noise_run == 16'h0000);
    c_gain_clamp: cover property (I_FRAME_STB && low_gain == GAIN_MAX);
endmodule

/* File: testbench/nplf_frame_src.sv */
// upstream analysis model: presents a frame set together with its strobe
`timescale 1ns/100ps
module nplf_frame_src (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_go,
    input wire nplf_pkg::nplf_frame_type i_frame,
    output logic o_stb,
    output nplf_pkg::nplf_frame_type o_frame
);
    import nplf_pkg::*;
    nplf_frame_type last_r;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            last_r <= '0;
        end else if (i_go) begin
            last_r <= i_frame;
        end
    end
    // inputs travel with the strobe; between strobes the lines show junk
    assign o_stb = i_go;
    assign o_frame = i_go ? i_frame : ~last_r;
endmodule

/* File: testbench/tb_nplf_features.sv */
// self-checking bench for the frame feature block
`timescale 1ns/100ps
module tb_nplf_features;
    import nplf_pkg::*;
    logic I_SYS_CLK = 1'b0;
    logic I_RST_B = 1'b0;
    logic go = 1'b0;
    logic stb;
    logic O_FEAT_VALID;
    logic exp_v = 1'b0;
    nplf_frame_type fin = '0;
    nplf_frame_type frm;
    nplf_feat_type O_FEAT;
    nplf_feat_type m = '0;
    int error_cnt = 0;
    int compares = 0;
    int seed = 52;
    int cyc = 0;
    always #25 I_SYS_CLK = ~I_SYS_CLK;
    nplf_frame_src nplf_frame_src_i (.i_clk(I_SYS_CLK), .i_rst_b(I_RST_B), .i_go(go),
        .i_frame(fin), .o_stb(stb), .o_frame(frm));
    nplf_features nplf_features_i (.I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B), .I_FRAME_STB(stb),
        .I_FRAME(frm), .O_FEAT_VALID(O_FEAT_VALID), .O_FEAT(O_FEAT));
    task automatic summarize();
        if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge I_SYS_CLK) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic cmp_b(string n, logic e, logic g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cmp_c(string n, logic [CNT_W-1:0] e, logic [CNT_W-1:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cmp_v(string n, logic [VAL_W-1:0] e, logic [VAL_W-1:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    function automatic logic signed [VAL_W-1:0] sm(logic signed [VAL_W-1:0] y,
            logic signed [VAL_W-1:0] x, logic [COEF_W-1:0] a);
        longint d;
        longint ca;
        d = x - y;
        ca = a;
        return VAL_W'(y + ((d * ca) >>> FRAC_BITS));
    endfunction
    function automatic logic signed [VAL_W-1:0] gain(logic [NRG_W-1:0] n, logic [NRG_W-1:0] d);
        logic [63:0] q;
        if (d == 0) return GAIN_MAX;
        q = ({32'h0, n} << FRAC_BITS) / d;
        return (q > 64'h8000) ? GAIN_MAX : VAL_W'(q);
    endfunction
    function automatic logic signed [VAL_W-1:0] mx(logic signed [VAL_W-1:0] a,
            logic signed [VAL_W-1:0] b);
        return (a > b) ? a : b;
    endfunction
    function automatic nplf_feat_type step(nplf_feat_type s, nplf_frame_type f);
        nplf_feat_type n;
        logic signed [VAL_W-1:0] rise;
        logic signed [VAL_W-1:0] dn;
        logic signed [VAL_W-1:0] g;
        n = s;
        rise = f.frame_energy - f.long_term_min_energy;
        dn = f.frame_energy - f.noise_level;
        if (s.energy_pause_counter >= 0 && rise > RISE_THR) n.energy_pause_counter = PAUSE_ACTIVE;
        else if (s.energy_pause_counter == PAUSE_ACTIVE && rise < RISE_THR) n.energy_pause_counter = 0;
        if (n.energy_pause_counter >= 0 && n.energy_pause_counter != PAUSE_MAX)
            n.energy_pause_counter = n.energy_pause_counter + 16'sh0001;
        g = gain(f.energy_order0, f.energy_order2);
        n.low_order_pred_gain = g;
        n.low_gain_avg = sm(s.low_gain_avg, g, COEF_0P15);
        n.low_dev = (n.low_gain_avg > g) ? n.low_gain_avg - g : g - n.low_gain_avg;
        n.low_dev_avg = sm(s.low_dev_avg, n.low_dev,
            (n.low_dev < s.low_dev_avg) ? COEF_0P10 : COEF_0P20);
        n.low_peak = mx(n.low_dev_avg, n.low_dev);
        g = gain(f.energy_order2, f.energy_order16);
        n.high_order_pred_gain = g;
        n.high_fast_avg = sm(s.high_fast_avg, g, (g > s.high_fast_avg) ? COEF_0P20 : COEF_0P03);
        n.slow_high_order_avg = sm(s.slow_high_order_avg, g, COEF_0P02);
        n.high_dev = n.high_fast_avg - n.slow_high_order_avg;
        n.high_dev_avg = sm(s.high_dev_avg, n.high_dev,
            (n.high_dev < s.high_dev_avg) ? COEF_0P02 : COEF_0P05);
        n.high_peak = mx(n.high_dev_avg, n.high_dev);
        n.noise_distance = sm(s.noise_distance, dn, COEF_0P03);
        n.noise_track = sm(s.noise_track, (dn < NEAR_THR) ? ONE_VAL : VAL_RESET, COEF_0P03);
        if (n.noise_track >= TRACK_THR) n.near_noise_run = 0;
        else if (s.near_noise_run != RUN_MAX) n.near_noise_run = s.near_noise_run + 16'h0001;
        n.min_energy_distance = sm(s.min_energy_distance, rise, COEF_0P03);
        return n;
    endfunction
    task automatic check_out();
        cmp_b("valid", exp_v, O_FEAT_VALID);
        cmp_c("pause", m.energy_pause_counter, O_FEAT.energy_pause_counter);
        cmp_v("lgain", m.low_order_pred_gain, O_FEAT.low_order_pred_gain);
        cmp_v("lavg", m.low_gain_avg, O_FEAT.low_gain_avg);
        cmp_v("ldev", m.low_dev, O_FEAT.low_dev);
        cmp_v("ldavg", m.low_dev_avg, O_FEAT.low_dev_avg);
        cmp_v("lpeak", m.low_peak, O_FEAT.low_peak);
        cmp_v("hgain", m.high_order_pred_gain, O_FEAT.high_order_pred_gain);
        cmp_v("hfast", m.high_fast_avg, O_FEAT.high_fast_avg);
        cmp_v("hslow", m.slow_high_order_avg, O_FEAT.slow_high_order_avg);
        cmp_v("hdev", m.high_dev, O_FEAT.high_dev);
        cmp_v("hdavg", m.high_dev_avg, O_FEAT.high_dev_avg);
        cmp_v("hpeak", m.high_peak, O_FEAT.high_peak);
        cmp_v("ndist", m.noise_distance, O_FEAT.noise_distance);
        cmp_v("ntrk", m.noise_track, O_FEAT.noise_track);
        cmp_c("nrun", m.near_noise_run, O_FEAT.near_noise_run);
        cmp_v("mdist", m.min_energy_distance, O_FEAT.min_energy_distance);
    endtask
    task automatic frame(logic g, nplf_frame_type f);
        @(negedge I_SYS_CLK);
        check_out();
        go = g;
        fin = f;
        exp_v = g;
        if (g) m = step(m, f);
    endtask
    function automatic int rnd(int span);
        return int'($unsigned($random(seed)) % span);
    endfunction
    // rise and residual energies chosen by hand; den0 forces a zero residual
    function automatic nplf_frame_type cf(int rise, logic den0);
        nplf_frame_type f;
        f.long_term_min_energy = 24'sh014000;
        f.frame_energy = VAL_W'(32'sh14000 + rise);
        f.noise_level = 24'sh010000;
        f.energy_order0 = 32'h00010000;
        f.energy_order2 = den0 ? 32'h0 : 32'h00004000;
        f.energy_order16 = den0 ? 32'h0 : 32'h00020000;
        return f;
    endfunction
    function automatic nplf_frame_type rf(logic far);
        nplf_frame_type f;
        f.long_term_min_energy = VAL_W'(81920 + rnd(81920));
        f.frame_energy = VAL_W'(f.long_term_min_energy - 40960 + rnd(102400));
        f.noise_level = VAL_W'(f.frame_energy - (far ? 122880 : rnd(81920)));
        f.energy_order0 = NRG_W'(rnd(1 << 20) + 1);
        f.energy_order2 = NRG_W'(rnd(1 << 18));
        f.energy_order16 = NRG_W'(rnd(1 << 18));
        return f;
    endfunction
    initial begin
        repeat (16) @(negedge I_SYS_CLK);
        I_RST_B = 1'b1;
        frame(1'b1, cf(0, 1'b0));
        frame(1'b1, cf(20481, 1'b0));
        frame(1'b1, cf(20480, 1'b1));
        frame(1'b1, cf(20479, 1'b1));
        frame(1'b0, cf(0, 1'b0));
        frame(1'b1, cf(20480, 1'b0));
        repeat (300) frame(rnd(4) != 0, rf(1'b0));
        repeat (150) frame(1'b1, rf(1'b1));
        @(negedge I_SYS_CLK);
        check_out();
        I_RST_B = 1'b0;
        go = 1'b0;
        repeat (2) @(negedge I_SYS_CLK);
        m = '0;
        exp_v = 1'b0;
        check_out();
        I_RST_B = 1'b1;
        repeat (100) frame(1'b1, rf(1'b0));
        frame(1'b0, rf(1'b0));
        @(negedge I_SYS_CLK);
        check_out();
        summarize();
    end
endmodule
